// ===== shared/uart_dma_pkg.sv
// Register map, field positions and reset values of the serial receive DMA block.
// Assumes a 32-bit Avalon-MM slave with byte addresses, word aligned.
package uart_dma_pkg;
  localparam int AW = 6;
  // Register byte offsets
  localparam logic [AW-1:0] OFS_CTL   = 6'h00;
  localparam logic [AW-1:0] OFS_STAT  = 6'h04;
  localparam logic [AW-1:0] OFS_RXD   = 6'h08;
  localparam logic [AW-1:0] OFS_TXD   = 6'h0c;
  localparam logic [AW-1:0] OFS_DIVL  = 6'h10;
  localparam logic [AW-1:0] OFS_DIVH  = 6'h14;
  localparam logic [AW-1:0] OFS_DCTL  = 6'h18;
  localparam logic [AW-1:0] OFS_PERI  = 6'h1c;
  localparam logic [AW-1:0] OFS_HI    = 6'h20;
  localparam logic [AW-1:0] OFS_START = 6'h24;
  localparam logic [AW-1:0] OFS_END   = 6'h28;
  localparam logic [AW-1:0] OFS_CUR   = 6'h2c;
  localparam logic [AW-1:0] OFS_BUF   = 6'h30;
  localparam logic [AW-1:0] OFS_WIN   = 6'h34;
  localparam logic [AW-1:0] OFS_RAMD  = 6'h38;
  // Serial control fields
  localparam int C_RX_EN = 0;
  localparam int C_TX_EN = 1;
  localparam int C_PAR   = 2;
  localparam int C_EVEN  = 3;
  localparam int C_CTS   = 4;
  localparam int C_STOP2 = 5;
  // Status fields
  localparam int S_RX_RDY  = 0;
  localparam int S_TX_BUSY = 1;
  localparam int S_PERR    = 2;
  localparam int S_FERR    = 3;
  localparam int S_OVR     = 4;
  localparam int S_PEND0   = 5;
  localparam int S_PEND1   = 6;
  localparam int S_DMA_IRQ = 7;
  localparam int S_DMA_OFF = 8;
  // DMA control fields
  localparam int D_EN   = 0;
  localparam int D_LOOP = 1;
  localparam int D_DIR  = 2;
  localparam int D_IRQ  = 3;
  localparam int D_WORD = 4;
  localparam int D_TRIG = 5;
  // Encodings and reset values
  localparam logic [7:0] PERIPH_RX_ID = 8'h01;
  localparam logic       TRIG_RX      = 1'b0;
  localparam logic [7:0] DIVL_RST     = 8'h01;
  localparam logic [7:0] DIVH_RST     = 8'h00;
  localparam logic [3:0] SUB_LAST     = 4'hf;
  localparam logic [3:0] SUB_MID      = 4'h7;
endpackage : uart_dma_pkg

// ===== src/serial_rx_core.sv
// Oversampling serial receiver and the shared 16x bit-rate tick.
// Assumes i_rx is an asynchronous pin; the divisor comes from registers on i_clk_sys.
`timescale 1ns/1ps
`default_nettype none
module serial_rx_core
  import uart_dma_pkg::*;
(
  // Clock and reset
  input  wire logic        i_clk_sys,
  input  wire logic        i_nrst,
  // Configuration
  input  wire logic [15:0] i_div,
  input  wire logic        i_en,
  input  wire logic        i_par_en,
  input  wire logic        i_even,
  // Serial pin
  input  wire logic        i_rx,
  // Results
  output logic             o_tick,
  output logic             o_valid,
  output logic [7:0]       o_data,
  output logic             o_perr,
  output logic             o_ferr
);
  import uart_dma_pkg::*;
  typedef enum logic [2:0] {R_IDLE, R_START, R_DATA, R_PAR, R_STOP} rx_state_t;
  typedef struct packed {
    logic [2:0]  sync;
    logic        line;
    logic [15:0] dcnt;
    logic        tick;
    rx_state_t   st;
    logic [3:0]  sub;
    logic [2:0]  bitn;
    logic [7:0]  sh;
    logic        par;
    logic        valid;
    logic        perr;
    logic        ferr;
  } rx_t;
  rx_t r_reg, r_next;

  always_comb begin
    r_next = r_reg;
    r_next.valid = 1'b0;
    r_next.sync = {r_reg.sync[1:0], i_rx};
    // Only the second and third stages are compared, never the first
    if (r_reg.sync[1] == r_reg.sync[2]) r_next.line = r_reg.sync[2];
    r_next.tick = 1'b0;
    r_next.dcnt = r_reg.dcnt + 16'h1;
    if (r_reg.dcnt + 16'h1 >= i_div) begin
      r_next.dcnt = 16'h0;
      r_next.tick = 1'b1;
    end
    case (r_reg.st)
      R_IDLE: begin
        r_next.sub = 4'h0;
        if (i_en && !r_reg.line) r_next.st = R_START;
      end
      default: begin
        if (r_reg.tick) begin
          r_next.sub = r_reg.sub + 4'h1;
          if (r_reg.st == R_START && r_reg.sub == SUB_MID) begin
            r_next.sub = 4'h0;
            r_next.bitn = 3'h0;
            r_next.par = 1'b0;
            r_next.st = r_reg.line ? R_IDLE : R_DATA;
          end else if (r_reg.st != R_START && r_reg.sub == SUB_LAST) begin
            case (r_reg.st)
              R_DATA: begin
                r_next.sh = {r_reg.line, r_reg.sh[7:1]};
                r_next.par = r_reg.par ^ r_reg.line;
                r_next.bitn = r_reg.bitn + 3'h1;
                if (r_reg.bitn == 3'h7) r_next.st = i_par_en ? R_PAR : R_STOP;
              end
              R_PAR: begin
                r_next.perr = r_reg.par ^ r_reg.line ^ ~i_even;
                r_next.st = R_STOP;
              end
              default: begin
                r_next.ferr = ~r_reg.line;
                r_next.valid = 1'b1;
                r_next.st = R_IDLE;
                if (!i_par_en) r_next.perr = 1'b0;
              end
            endcase
          end
        end
      end
    endcase
  end

  always_ff @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      r_reg <= '{sync: 3'h7, line: 1'b1, st: R_IDLE, default: '0};
    end else begin
      r_reg <= r_next;
    end
  end

  assign o_tick  = r_reg.tick;
  assign o_valid = r_reg.valid;
  assign o_data  = r_reg.sh;
  assign o_perr  = r_reg.perr;
  assign o_ferr  = r_reg.ferr;
endmodule : serial_rx_core
`default_nettype wire

// ===== src/uart_rx_pingpong_dma.sv
// Serial port with a receive DMA channel feeding two alternating buffers in a local RAM.
// Assumes an Avalon-MM master on i_clk_sys; serial and flow-control pins are asynchronous.
//
// What this block does
// - Start address is high-nibble-low over start byte
// - End address is high-nibble-high over end byte
// - Peripheral select picks serial receive data register
// - Loop mode wraps to start and continues
// - Direction bit moves peripheral data into RAM
// - Control holds irq, word, trigger, enable bits
// - Channel disables itself when buffers are exhausted
// - Two alternating receive buffers, each as long as the programmed start..end range
// - Reader drains one buffer, then marks it empty
// - Swap only into a read-complete buffer
// - Both buffers unread asserts request-to-send
// - Request-to-send low after fill, high after read
// - Clear-to-send input gates transmitter when enabled
// - Separate receive and transmit enable bits
// - Parity enable and even parity select
// - Received character not stored by the DMA channel raises flag, data register returns it
// - Transmit data write sends the byte
// - Buffer full raises the DMA interrupt
// - Eight data bits, lsb first, start, stop bits
// - Bit rate is clock over sixteen times divisor
`timescale 1ns/1ps
`default_nettype none
module uart_rx_pingpong_dma
  import uart_dma_pkg::*;
#(
  parameter int RAM_AW = 12
)(
  // Clock and reset
  input  wire logic                  i_clk_sys,
  input  wire logic                  i_nrst,
  // Avalon-MM slave
  input  wire logic [uart_dma_pkg::AW-1:0] i_avs_address,
  input  wire logic                  i_avs_read,
  input  wire logic                  i_avs_write,
  input  wire logic [31:0]           i_avs_writedata,
  input  wire logic [3:0]            i_avs_byteenable,
  output logic [31:0]                o_avs_readdata,
  output logic                       o_avs_waitrequest,
  // Serial and flow-control pins
  input  wire logic                  i_rx,
  output logic                       o_tx,
  input  wire logic                  i_cts_n,
  output logic                       o_rts_n,
  // Event outputs
  output logic                       o_rx_irq,
  output logic                       o_dma_irq
);
  import uart_dma_pkg::*;
  typedef enum logic [2:0] {T_IDLE, T_START, T_DATA, T_PAR, T_STOP} tx_state_t;
  typedef struct packed {
    // Software-visible registers
    logic [5:0]  ctl;
    logic [5:0]  dctl;
    logic [7:0]  periph;
    logic [7:0]  hi;
    logic [7:0]  slo;
    logic [7:0]  elo;
    logic [7:0]  divl;
    logic [7:0]  divh;
    // DMA channel position and buffer bookkeeping
    logic [11:0] cur;
    logic        sel;
    logic [1:0]  pend;
    logic [11:0] win;
    // Receive data register, its flags and the DMA channel flags
    logic [7:0]  rx_data;
    logic        rx_rdy;
    logic        ovr;
    logic        perr;
    logic        ferr;
    logic        dma_irq;
    logic        dma_off;
    // Transmitter
    logic [7:0]  tx_buf;
    logic        tx_full;
    tx_state_t   tst;
    logic [3:0]  tsub;
    logic [2:0]  tbit;
    logic [7:0]  tsh;
    logic        tpar;
    logic        tstop;
    logic        tx_o;
    // Pin sampler, flow control and bus answer
    logic [2:0]  cts_s;
    logic        cts_ok;
    logic        rts_n;
    logic        wait_r;
    logic [31:0] rdata;
  } st_t;
  st_t r_reg, r_next;

  logic [7:0]        ram [2**RAM_AW];
  logic              ram_we;
  logic [RAM_AW-1:0] ram_wa;
  logic [7:0]        ram_wd;
  logic              tick;
  logic              rx_valid;
  logic [7:0]        rx_byte;
  logic              rx_perr;
  logic              rx_ferr;
  logic              acc;
  logic              wr;
  logic              rd;
  logic              dma_go;
  logic [7:0]        wd;

  // Buffer bounds: the high register's low nibble tops the start byte, its high
  // nibble tops the end byte
  function automatic logic [11:0] start_addr(input logic [7:0] h, input logic [7:0] sl);
    start_addr = {h[3:0], sl};
  endfunction : start_addr

  function automatic logic [11:0] end_addr(input logic [7:0] h, input logic [7:0] el);
    end_addr = {h[7:4], el};
  endfunction : end_addr

  // Buffer 0 spans the programmed start..end; buffer 1 follows it with the same length
  function automatic logic [11:0] buf_base(input logic s, input logic [7:0] h,
                                           input logic [7:0] sl, input logic [7:0] el);
    logic [11:0] b;
    logic [11:0] e;
    b = start_addr(h, sl);
    e = end_addr(h, el);
    buf_base = s ? (e + 12'h1) : b;
  endfunction : buf_base

  function automatic logic [11:0] buf_last(input logic s, input logic [7:0] h,
                                           input logic [7:0] sl, input logic [7:0] el);
    logic [11:0] b;
    logic [11:0] e;
    b = start_addr(h, sl);
    e = end_addr(h, el);
    buf_last = s ? (e + (e - b) + 12'h1) : e;
  endfunction : buf_last

  serial_rx_core u_rx (
    .i_clk_sys (i_clk_sys),
    .i_nrst    (i_nrst),
    .i_div     ({r_reg.divh, r_reg.divl}),
    .i_en      (r_reg.ctl[C_RX_EN]),
    .i_par_en  (r_reg.ctl[C_PAR]),
    .i_even    (r_reg.ctl[C_EVEN]),
    .i_rx      (i_rx),
    .o_tick    (tick),
    .o_valid   (rx_valid),
    .o_data    (rx_byte),
    .o_perr    (rx_perr),
    .o_ferr    (rx_ferr)
  );

  always_comb begin
    r_next = r_reg;
    ram_we = 1'b0;
    ram_wa = r_reg.cur[RAM_AW-1:0];
    ram_wd = rx_byte;
    wd = i_avs_writedata[7:0];
    // A request commits at the edge where waitrequest is low
    acc = (i_avs_read | i_avs_write) & ~r_reg.wait_r;
    wr = i_avs_write & acc & i_avs_byteenable[0];
    rd = i_avs_read & acc;
    dma_go = r_reg.dctl[D_EN] & r_reg.dctl[D_DIR]
           & (r_reg.periph == PERIPH_RX_ID)
           & (r_reg.dctl[D_TRIG] == TRIG_RX);

    // Exactly one wait cycle per access; readdata then stands until the next access, read or write
    r_next.wait_r = 1'b1;
    if ((i_avs_read | i_avs_write) && r_reg.wait_r) begin
      r_next.wait_r = 1'b0;
      case (i_avs_address)
        OFS_CTL:   r_next.rdata = {26'h0, r_reg.ctl};
        OFS_STAT:  r_next.rdata = {23'h0, r_reg.dma_off, r_reg.dma_irq, r_reg.pend,
                                   r_reg.ovr, r_reg.ferr, r_reg.perr,
                                   r_reg.tx_full | (r_reg.tst != T_IDLE), r_reg.rx_rdy};
        OFS_RXD:   r_next.rdata = {24'h0, r_reg.rx_data};
        OFS_DIVL:  r_next.rdata = {24'h0, r_reg.divl};
        OFS_DIVH:  r_next.rdata = {24'h0, r_reg.divh};
        OFS_DCTL:  r_next.rdata = {26'h0, r_reg.dctl};
        OFS_PERI:  r_next.rdata = {24'h0, r_reg.periph};
        OFS_HI:    r_next.rdata = {24'h0, r_reg.hi};
        OFS_START: r_next.rdata = {24'h0, r_reg.slo};
        OFS_END:   r_next.rdata = {24'h0, r_reg.elo};
        OFS_CUR:   r_next.rdata = {20'h0, r_reg.cur};
        OFS_BUF:   r_next.rdata = {30'h0, r_reg.pend};
        OFS_WIN:   r_next.rdata = {20'h0, r_reg.win};
        OFS_RAMD:  r_next.rdata = {24'h0, ram[r_reg.win[RAM_AW-1:0]]};
        default:   r_next.rdata = 32'h0;
      endcase
    end

    // Software side: stores, clears and read side effects
    if (rd && i_avs_address == OFS_RXD) r_next.rx_rdy = 1'b0;
    if (wr) begin
      case (i_avs_address)
        OFS_CTL:   r_next.ctl = wd[5:0];
        OFS_STAT: begin
          if (wd[S_PERR])    r_next.perr = 1'b0;
          if (wd[S_FERR])    r_next.ferr = 1'b0;
          if (wd[S_OVR])     r_next.ovr = 1'b0;
          if (wd[S_DMA_IRQ]) r_next.dma_irq = 1'b0;
        end
        OFS_TXD: begin
          r_next.tx_buf = wd;
          r_next.tx_full = 1'b1;
        end
        OFS_DIVL:  r_next.divl = wd;
        OFS_DIVH:  r_next.divh = wd;
        OFS_DCTL: begin
          // Word mode is stored only; every transfer moves one byte
          r_next.dctl = wd[5:0];
          if (wd[D_EN] && !r_reg.dctl[D_EN]) begin
            r_next.cur = buf_base(r_reg.sel, r_reg.hi, r_reg.slo, r_reg.elo);
            r_next.dma_off = 1'b0;
          end
        end
        OFS_PERI:  r_next.periph = wd;
        OFS_HI:    r_next.hi = wd;
        OFS_START: r_next.slo = wd;
        OFS_END:   r_next.elo = wd;
        OFS_BUF: begin
          // Writing a one marks that buffer read-complete
          if (wd[0]) r_next.pend[0] = 1'b0;
          if (wd[1]) r_next.pend[1] = 1'b0;
        end
        OFS_WIN:   r_next.win = {i_avs_writedata[11:8], wd};
        default: ;
      endcase
    end

    // Clear-to-send sampler: the first stage feeds only the second
    r_next.cts_s = {r_reg.cts_s[1:0], i_cts_n};
    if (r_reg.cts_s[1] == r_reg.cts_s[2]) r_next.cts_ok = ~r_reg.cts_s[2];

    // Transmitter
    case (r_reg.tst)
      T_IDLE: begin
        r_next.tx_o = 1'b1;
        if (r_reg.tx_full && r_reg.ctl[C_TX_EN]
            && (!r_reg.ctl[C_CTS] || r_reg.cts_ok)) begin
          r_next.tst = T_START;
          r_next.tsh = r_reg.tx_buf;
          r_next.tpar = ^r_reg.tx_buf;
          r_next.tx_full = 1'b0;
          r_next.tsub = 4'h0;
          r_next.tx_o = 1'b0;
        end
      end
      default: begin
        if (tick) begin
          r_next.tsub = r_reg.tsub + 4'h1;
          if (r_reg.tsub == SUB_LAST) begin
            case (r_reg.tst)
              T_START: begin
                r_next.tst = T_DATA;
                r_next.tbit = 3'h0;
                r_next.tx_o = r_reg.tsh[0];
              end
              T_DATA: begin
                r_next.tsh = {1'b0, r_reg.tsh[7:1]};
                r_next.tbit = r_reg.tbit + 3'h1;
                r_next.tx_o = r_reg.tsh[1];
                if (r_reg.tbit == 3'h7) begin
                  r_next.tst = r_reg.ctl[C_PAR] ? T_PAR : T_STOP;
                  r_next.tx_o = r_reg.ctl[C_PAR] ? (r_reg.tpar ^ ~r_reg.ctl[C_EVEN])
                                                 : 1'b1;
                  r_next.tstop = r_reg.ctl[C_STOP2];
                end
              end
              T_PAR: begin
                r_next.tst = T_STOP;
                r_next.tx_o = 1'b1;
              end
              default: begin
                // Second stop bit holds the line high one more bit time
                if (r_reg.tstop) r_next.tstop = 1'b0;
                else r_next.tst = T_IDLE;
              end
            endcase
          end
        end
      end
    endcase

    // Received characters: into the active buffer, else to the data register
    if (rx_valid) begin
      if (dma_go && !r_reg.pend[r_reg.sel]) begin
        ram_we = 1'b1;
        r_next.cur = r_reg.cur + 12'h1;
        if (r_reg.cur == buf_last(r_reg.sel, r_reg.hi, r_reg.slo, r_reg.elo)) begin
          r_next.pend[r_reg.sel] = 1'b1;
          if (r_reg.dctl[D_IRQ]) r_next.dma_irq = 1'b1;
          r_next.cur = buf_base(r_reg.sel, r_reg.hi, r_reg.slo, r_reg.elo);
          if (!r_reg.dctl[D_LOOP]) r_next.dctl[D_EN] = 1'b0;
        end
      end else begin
        if (dma_go) begin
          // No free buffer left: hand reception back to the plain receiver
          r_next.dctl[D_EN] = 1'b0;
          r_next.dma_off = 1'b1;
        end
        r_next.rx_data = rx_byte;
        // A read committing now is no overrun; a new overrun beats a clear
        r_next.ovr = r_next.ovr | r_next.rx_rdy;
        r_next.rx_rdy = 1'b1;
        r_next.perr = rx_perr;
        r_next.ferr = rx_ferr;
      end
    end

    // Move to the other buffer only once it is read-complete
    // Next-state flags are used so a fill and a release in one cycle are both seen
    if (r_next.pend[r_next.sel] && !r_next.pend[~r_next.sel]) begin
      r_next.sel = ~r_next.sel;
      r_next.cur = buf_base(r_next.sel, r_reg.hi, r_reg.slo, r_reg.elo);
    end
    // Taken from next-state flags so the pin moves on the same edge as the fill
    r_next.rts_n = ~(r_next.pend[0] & r_next.pend[1]);
  end

  always_ff @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      r_reg <= '{divl: DIVL_RST, divh: DIVH_RST, tst: T_IDLE, tx_o: 1'b1,
                 cts_s: 3'h7, rts_n: 1'b1, wait_r: 1'b1, default: '0};
    end else begin
      r_reg <= r_next;
    end
  end

  // Buffer storage kept out of the state record; it has no reset
  always_ff @(posedge i_clk_sys) begin
    if (ram_we) ram[ram_wa] <= ram_wd;
  end

  assign o_avs_readdata    = r_reg.rdata;
  assign o_avs_waitrequest = r_reg.wait_r;
  assign o_tx              = r_reg.tx_o;
  assign o_rts_n           = r_reg.rts_n;
  assign o_rx_irq          = r_reg.rx_rdy;
  assign o_dma_irq         = r_reg.dma_irq;
endmodule : uart_rx_pingpong_dma
`default_nettype wire

// ===== sim/uart_dma_asserts.sv
// Checker for the serial receive DMA block: bus timing, flow control, serial framing.
// Assumes bind to the top module and a single clock domain.
`timescale 1ns/1ps
`default_nettype none
module uart_dma_asserts
  import uart_dma_pkg::*;
(
  // Clock and reset
  input  wire logic                        i_clk_sys,
  input  wire logic                        i_nrst,
  // Avalon-MM slave
  input  wire logic [uart_dma_pkg::AW-1:0] i_avs_address,
  input  wire logic                        i_avs_read,
  input  wire logic                        i_avs_write,
  input  wire logic [31:0]                 i_avs_writedata,
  input  wire logic [3:0]                  i_avs_byteenable,
  input  wire logic [31:0]                 o_avs_readdata,
  input  wire logic                        o_avs_waitrequest,
  // Pins and events
  input  wire logic                        o_tx,
  input  wire logic                        i_cts_n,
  input  wire logic                        o_rts_n,
  input  wire logic                        o_rx_irq,
  input  wire logic                        o_dma_irq
);
  logic       wr_done;
  logic       buf_clr;
  logic       stat_clr;
  logic       rxd_rd;
  logic [7:0] ctl_reg;
  assign wr_done  = i_avs_write && !o_avs_waitrequest && i_avs_byteenable[0];
  assign buf_clr  = wr_done && i_avs_address == OFS_BUF && |i_avs_writedata[1:0];
  assign stat_clr = wr_done && i_avs_address == OFS_STAT && i_avs_writedata[S_DMA_IRQ];
  assign rxd_rd   = i_avs_read && !o_avs_waitrequest && i_avs_address == OFS_RXD;
  // Shadow of the serial control register, since the checker cannot see inside
  always_ff @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      ctl_reg <= 8'h00;
    end else if (wr_done && i_avs_address == OFS_CTL) begin
      ctl_reg <= i_avs_writedata[7:0];
    end
  end
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_nrst);
  sequence s_req;
    (i_avs_read || i_avs_write) && o_avs_waitrequest;
  endsequence
  sequence s_answer;
    !o_avs_waitrequest ##1 o_avs_waitrequest;
  endsequence
  sequence s_bit_low;
    !o_tx [*8] ##1 !o_tx [*8];
  endsequence
  AST_ONE_WAIT: assert property (s_req |=> s_answer)
    else $error("waitrequest did not drop for exactly one cycle");
  AST_IDLE_WAIT: assert property (!(i_avs_read || i_avs_write) |=> o_avs_waitrequest)
    else $error("waitrequest low without a request");
  AST_UNMAPPED_ZERO: assert property (i_avs_read && !o_avs_waitrequest &&
    i_avs_address == 6'h3c |-> o_avs_readdata == 32'h0)
    else $error("unmapped read returned nonzero");
  AST_RTS_RISE: assert property ($rose(o_rts_n) |->
    $past(buf_clr) || $past(buf_clr, 2) || $past(buf_clr, 3))
    else $error("request-to-send released without a buffer read");
  AST_RTS_HOLD: assert property (!o_rts_n && !buf_clr && !$past(buf_clr) &&
    !$past(buf_clr, 2) |=> !o_rts_n)
    else $error("request-to-send released while both buffers unread");
  AST_TX_BIT_LEN: assert property ($fell(o_tx) |-> s_bit_low)
    else $error("serial bit shorter than sixteen clocks");
  AST_TX_ENABLE: assert property ($fell(o_tx) |-> ctl_reg[C_TX_EN])
    else $error("transmitter ran while disabled");
  AST_CTS_GATE: assert property ((ctl_reg[C_CTS] && i_cts_n) [*8] |=> !$fell(o_tx))
    else $error("transmit started without clear-to-send");
  AST_RX_IRQ_CLR: assert property (rxd_rd |-> ##2 !o_rx_irq)
    else $error("receive flag not cleared by data read");
  AST_DMA_IRQ_STICKY: assert property (o_dma_irq && !stat_clr &&
    !$past(stat_clr) |=> o_dma_irq)
    else $error("buffer-full flag dropped without clear");
endmodule : uart_dma_asserts
bind uart_rx_pingpong_dma uart_dma_asserts i_chk (
  .i_clk_sys(i_clk_sys), .i_nrst(i_nrst), .i_avs_address(i_avs_address),
  .i_avs_read(i_avs_read), .i_avs_write(i_avs_write), .i_avs_writedata(i_avs_writedata),
  .i_avs_byteenable(i_avs_byteenable), .o_avs_readdata(o_avs_readdata),
  .o_avs_waitrequest(o_avs_waitrequest), .o_tx(o_tx), .i_cts_n(i_cts_n),
  .o_rts_n(o_rts_n), .o_rx_irq(o_rx_irq), .o_dma_irq(o_dma_irq)
);
`default_nettype wire

// ===== sim/remote_serial_peer.sv
// Behavioural remote serial transmitter with hardware flow control.
// Assumes 16 clocks per bit (divisor 1) and even parity on the link.
`timescale 1ns/1ps
`default_nettype none
module remote_serial_peer #(
  parameter int BIT_CYC = 16
)(
  // Clock
  input  wire logic i_clk_sys,
  // Flow control from the device
  input  wire logic i_rts_n,
  // Lines toward the device
  output var logic  o_line,
  output var logic  o_cts_n
);
  initial begin
    o_line = 1'b1;
    o_cts_n = 1'b0;
  end
  // Call just after a clock edge; obey=0 ignores flow control on purpose
  task automatic send_byte(input logic [7:0] d, input bit obey);
    logic [10:0] fr;
    fr = {1'b1, ^d, d, 1'b0};
    while (obey && i_rts_n !== 1'b1) @(posedge i_clk_sys);
    // Two idle bits after the stop bit give the device time to store the byte
    for (int i = 0; i < 13; i++) begin
      o_line <= (i < 11) ? fr[i] : 1'b1;
      repeat (BIT_CYC) @(posedge i_clk_sys);
    end
  endtask : send_byte
  task automatic set_cts(input logic v);
    o_cts_n <= v;
  endtask : set_cts
endmodule : remote_serial_peer
`default_nettype wire

// ===== sim/testbench.sv
// Self-checking bench: register access over Avalon-MM plus a remote serial peer.
// Assumes the divisor stays at its reset value 1, so one bit is 16 clocks.
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import uart_dma_pkg::*;
  localparam int LIMIT = 20000;
  logic          clk, nrst, rd, wr, tx, cts_n, rts_n, rx, rx_irq, dma_irq, wreq;
  logic [AW-1:0] addr;
  logic [31:0]   wdat, rdat, rv;
  logic [7:0]    pat [12];
  int            n_fail, tests_run, cyc, n;

  uart_rx_pingpong_dma i_dut (.i_clk_sys(clk), .i_nrst(nrst), .i_avs_address(addr),
    .i_avs_read(rd), .i_avs_write(wr), .i_avs_writedata(wdat), .i_avs_byteenable(4'hf),
    .o_avs_readdata(rdat), .o_avs_waitrequest(wreq), .i_rx(rx), .o_tx(tx),
    .i_cts_n(cts_n), .o_rts_n(rts_n), .o_rx_irq(rx_irq), .o_dma_irq(dma_irq));
  remote_serial_peer i_peer (.i_clk_sys(clk), .i_rts_n(rts_n), .o_line(rx), .o_cts_n(cts_n));

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  task automatic tally_and_finish();
    $display("Comparisons %0d, mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : tally_and_finish

  always @(posedge clk) begin
    cyc++;
    if (cyc == LIMIT) begin
      n_fail++;
      $display("ERROR t=%0t run did not finish in time", $time);
      tally_and_finish();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR t=%0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // One bus access; entered just after an edge, returns one edge after release
  task automatic av(input logic w, input logic [AW-1:0] a, input logic [11:0] d);
    addr <= a;
    wdat <= {20'h0, d};
    rd <= !w;
    wr <= w;
    do @(posedge clk); while (wreq !== 1'b0);
    rv = rdat;
    rd <= 1'b0;
    wr <= 1'b0;
    @(posedge clk);
  endtask : av

  task automatic rd_chk(input logic [AW-1:0] a, input logic [31:0] exp);
    av(1'b0, a, 12'h000);
    chk(rv, exp);
  endtask : rd_chk

  // Waits for a start bit, then samples each of thirteen bit times near its middle
  task automatic tx_chk(input logic [12:0] f);
    n = 0;
    while (tx !== 1'b0 && n < 200) begin
      @(posedge clk);
      n++;
    end
    repeat (8) @(posedge clk);
    for (int i = 0; i < 13; i++) begin
      chk(32'(tx), 32'(f[i]));
      repeat (16) @(posedge clk);
    end
  endtask : tx_chk

  initial begin
    nrst = 1'b0;
    rd = 1'b0;
    wr = 1'b0;
    addr = '0;
    wdat = '0;
    n_fail = 0;
    tests_run = 0;
    pat = '{8'ha5, 8'h3c, 8'h00, 8'hff, 8'h81, 8'h7e, 8'h01, 8'h80,
            8'h55, 8'haa, 8'h0f, 8'hf0};
    repeat (3) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    rd_chk(OFS_CTL, 32'h0);
    rd_chk(OFS_DCTL, 32'h0);
    rd_chk(OFS_DIVL, 32'h01);
    rd_chk(6'h3c, 32'h0);
    chk(32'(rts_n), 32'h1);
    $display("test reset values done");
    av(1'b1, OFS_CTL, 12'h01f);
    av(1'b1, OFS_PERI, 12'h001);
    av(1'b1, OFS_HI, 12'h0dd);
    av(1'b1, OFS_START, 12'h000);
    av(1'b1, OFS_END, 12'h003);
    av(1'b1, OFS_DCTL, 12'h01f);
    rd_chk(OFS_DCTL, 32'h1f);
    rd_chk(OFS_CUR, 32'hd00);
    $display("test channel setup done");
    for (int i = 0; i < 4; i++) i_peer.send_byte(pat[i], 1'b1);
    chk(32'(dma_irq), 32'h1);
    av(1'b1, OFS_STAT, 12'h080);
    rd_chk(OFS_BUF, 32'h1);
    rd_chk(OFS_CUR, 32'hd04);
    chk(32'(dma_irq), 32'h0);
    $display("test first buffer done");
    for (int i = 4; i < 8; i++) i_peer.send_byte(pat[i], 1'b1);
    chk(32'(rts_n), 32'h0);
    rd_chk(OFS_BUF, 32'h3);
    for (int i = 0; i < 8; i++) begin
      av(1'b1, OFS_WIN, 12'(12'hd00 + i));
      rd_chk(OFS_RAMD, {24'h0, pat[i]});
    end
    $display("test both buffers done");
    av(1'b1, OFS_BUF, 12'h001);
    rd_chk(OFS_BUF, 32'h2);
    chk(32'(rts_n), 32'h1);
    rd_chk(OFS_CUR, 32'hd00);
    $display("test buffer release done");
    for (int i = 8; i < 12; i++) i_peer.send_byte(pat[i], 1'b1);
    chk(32'(rts_n), 32'h0);
    i_peer.send_byte(8'h5a, 1'b0);
    av(1'b0, OFS_STAT, 12'h000);
    chk(32'(rv[S_DMA_OFF]), 32'h1);
    chk(32'(rv[S_PERR]), 32'h0);
    chk(32'(rx_irq), 32'h1);
    rd_chk(OFS_RXD, 32'h5a);
    rd_chk(OFS_DCTL, 32'h1e);
    av(1'b1, OFS_WIN, 12'hd00);
    rd_chk(OFS_RAMD, {24'h0, pat[8]});
    chk(32'(rx_irq), 32'h0);
    $display("test overflow to receiver done");
    i_peer.set_cts(1'b1);
    // The pin passes three sampling stages before it can hold a queued byte back
    repeat (6) @(posedge clk);
    av(1'b1, OFS_TXD, 12'h096);
    repeat (40) @(posedge clk);
    chk(32'(tx), 32'h1);
    i_peer.set_cts(1'b0);
    tx_chk({3'b111, ^8'h96, 8'h96, 1'b0});
    $display("test transmit frame done");
    // Odd parity, two stop bits; a second byte queued behind shows where its start lands
    av(1'b1, OFS_CTL, 12'h026);
    av(1'b1, OFS_TXD, 12'h096);
    av(1'b1, OFS_TXD, 12'h096);
    tx_chk({1'b0, 2'b11, ~^8'h96, 8'h96, 1'b0});
    $display("test odd parity two stop done");
    tally_and_finish();
  end
endmodule : testbench
`default_nettype wire
